// *** ccs_consts.vh ***
// Register offsets, field positions, reset values and widths for the colour select block.
// Included by the design file; holds definitions only.
`ifndef CCS_CONSTS_VH
`define CCS_CONSTS_VH
`define CCS_ADDR_W 16
`define CCS_OFF_CTRL2 16'hD016
`define CCS_OFF_BG0 16'hD021
`define CCS_OFF_BG1 16'hD022
`define CCS_OFF_BG2 16'hD023
`define CCS_OFF_MEMSET 16'hD018
`define CCS_OFF_STATUS 16'hD0F0
`define CCS_MC_BIT 4
`define CCS_CBASE_LO 0
`define CCS_CBASE_HI 3
`define CCS_BASE_SHIFT 11
`define CCS_CELL_MC_BIT 3
`define CCS_ROWS 3'h7
`define CCS_RST_REG 8'h00
`define CCS_RST_MEMSET 8'h0C
`define CCS_FIFO_W 12
`define CCS_FIFO_D 4
`define CCS_DOTS 3'h7
`endif

// *** ccs_fifo.v ***
// Holds no logic: the cell FIFO module is defined beside the colour select block.
// Assumes nothing of its surroundings.

// *** ccs_color_select.v ***
// Character cell colour selection: glyph row byte plus colour nibble in, colour dots out.
// Also holds the four-word cell FIFO between glyph fetch and the dot serialiser.
// Assumes an APB master on pclk and a pixel sink that may stall with dot_ready.
//
// What this block does
// [R01] Row byte bit 7 is the leftmost dot, bit 0 the rightmost.
// [R02] A glyph has eight row bytes 0..7 fetched top row to bottom row.
// [R03] Standard cell: 0 bit gives background 0, 1 bit gives cell colour.
// [R04] Control register bit 4 permits multicolour; clear forces standard cells.
// [R05] With multicolour on, colour nibble bit 3 selects multicolour cell.
// [R06] Standard cell in multicolour display uses colour value 0..7 as foreground.
// [R07] Multicolour cell decodes four bit pairs, each a double-width dot.
// [R08] Pair 00, 01, 10 output background registers 0, 1, 2.
// [R09] Pair 11 outputs low three bits of the cell colour nibble.
// [R10] Text cells take foreground from pair 11, not pair 10 as sprites do.
// [R11] Background registers pick 16 colours; multicolour foreground only 8.
// [R12] Colour registers are read on every dot, so writes act at once.
// [R13] Bits 3..1 of memory setup register select character base; bit 0 is ignored.
// [R14] Glyph address is character base plus eight times the code.
// [R15] Multicolour pair from bits 7..6 shows first, then 5..4, 3..2, 1..0.
// [R16] With multicolour disabled every cell is standard, colour bit 3 only a foreground bit.
`timescale 1ns/1ps
`include "ccs_consts.vh"
module ccs_color_select (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire cell_valid,
  output reg cell_ready,
  input wire [7:0] cell_code,
  input wire [3:0] cell_color,
  output reg [13:0] glyph_addr,
  output reg glyph_req,
  input wire [7:0] glyph_row,
  input wire glyph_ack,
  output reg [3:0] dot_color,
  output reg dot_valid,
  input wire dot_ready
);

  ////////////////////////////////////////////////////////////////////////////
  // Register file.

  reg [7:0] ctrl_two;
  reg [7:0] bg0;
  reg [7:0] bg1;
  reg [7:0] bg2;
  reg [7:0] mem_setup;
  reg [2:0] row_sel;
  reg busy;
  wire [15:0] addr;
  reg [31:0] next_rdata;
  reg addr_ok;
  wire setup_phase;
  wire write_take;

  assign addr = paddr[15:0];
  assign setup_phase = psel && !penable;
  // A write lands only on the edge where the access phase meets pready.
  assign write_take = psel && penable && pready && pwrite && addr_ok;

  always @* begin
    next_rdata = 32'h00000000;
    addr_ok = 1'b1;
    case (addr)
      `CCS_OFF_CTRL2: next_rdata = {24'h000000, ctrl_two};
      `CCS_OFF_BG0: next_rdata = {24'h000000, bg0};
      `CCS_OFF_BG1: next_rdata = {24'h000000, bg1};
      `CCS_OFF_BG2: next_rdata = {24'h000000, bg2};
      `CCS_OFF_MEMSET: next_rdata = {24'h000000, mem_setup};
      `CCS_OFF_STATUS: next_rdata = {28'h0000000, busy, row_sel};
      default: addr_ok = 1'b0;
    endcase
    if (paddr[31:16] != 16'h0000) begin
      addr_ok = 1'b0;
    end
  end

  // Slave answers in the first access cycle; pready is a registered pulse.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_two <= `CCS_RST_REG;
      bg0 <= `CCS_RST_REG;
      bg1 <= `CCS_RST_REG;
      bg2 <= `CCS_RST_REG;
      mem_setup <= `CCS_RST_MEMSET;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      if (setup_phase) begin
        pready <= 1'b1;
        pslverr <= !addr_ok;
        prdata <= (!pwrite && addr_ok) ? next_rdata : 32'h00000000;
      end
      if (write_take) begin
        case (addr)
          `CCS_OFF_CTRL2: ctrl_two <= pwdata[7:0];
          `CCS_OFF_BG0: bg0 <= pwdata[7:0];
          `CCS_OFF_BG1: bg1 <= pwdata[7:0];
          `CCS_OFF_BG2: bg2 <= pwdata[7:0];
          `CCS_OFF_MEMSET: mem_setup <= pwdata[7:0];
          default: ctrl_two <= ctrl_two;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Glyph fetch: one row byte per cell, the row selected by row_sel.

  localparam ST_IDLE = 2'b00;
  localparam ST_FETCH = 2'b01;
  localparam ST_PUSH = 2'b10;

  reg [1:0] state;
  reg [7:0] hold_row;
  reg [3:0] hold_color;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [11:0] fifo_out_data;
  reg fifo_pop;
  wire [13:0] char_base;
  wire [13:0] cell_offset;

  // Ready is a flop that tracks the idle state, so the port comes straight from a register.

  // Base in 2 KB steps from the field's upper bits; bit 0 of the field is ignored.
  assign char_base = {mem_setup[`CCS_CBASE_HI:`CCS_CBASE_LO+1], {`CCS_BASE_SHIFT{1'b0}}};
  // Eight row bytes per code, so the code sits three bits up with the row below it.
  assign cell_offset = {3'h0, cell_code, row_sel};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      glyph_addr <= 14'h0000;
      glyph_req <= 1'b0;
      hold_row <= 8'h00;
      hold_color <= 4'h0;
      busy <= 1'b0;
      cell_ready <= 1'b1;
    end else begin
      case (state)
        ST_IDLE: begin
          if (cell_valid) begin
            glyph_addr <= char_base + cell_offset; // see [R13] see [R14]
            hold_color <= cell_color;
            glyph_req <= 1'b1;
            busy <= 1'b1;
            cell_ready <= 1'b0;
            state <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (glyph_ack) begin
            glyph_req <= 1'b0;
            hold_row <= glyph_row;
            state <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          if (fifo_in_ready) begin
            busy <= 1'b0;
            cell_ready <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  ccs_fifo #(
    .WIDTH(`CCS_FIFO_W),
    .DEPTH(`CCS_FIFO_D)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(state == ST_PUSH),
    .in_ready(fifo_in_ready),
    .in_data({hold_color, hold_row}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Dot serialiser. Colours are looked up per dot so register writes show at once.

  reg [7:0] sh_row;
  reg [3:0] sh_color;
  reg [2:0] dot_idx;
  reg loaded;
  wire mc_cell;
  wire [1:0] pair;
  wire dot_bit;
  reg [3:0] next_color;
  wire advance;

  // A dot leaves when the sink takes it or when no dot is pending.
  assign advance = dot_ready || !dot_valid;
  assign mc_cell = ctrl_two[`CCS_MC_BIT] && sh_color[`CCS_CELL_MC_BIT]; // see [R04] see [R05] see [R16]
  // Pair index steps every second dot, bits 7..6 first, giving double-width dots.
  assign pair = sh_row[{~dot_idx[2:1], 1'b1} -: 2]; // see [R07] see [R15]
  assign dot_bit = sh_row[~dot_idx]; // see [R01]

  always @* begin
    fifo_pop = advance && (!loaded || dot_idx == `CCS_DOTS);
    if (mc_cell) begin
      case (pair) // see [R08] see [R10]
        2'b00: next_color = bg0[3:0];
        2'b01: next_color = bg1[3:0];
        2'b10: next_color = bg2[3:0];
        default: next_color = {1'b0, sh_color[2:0]}; // see [R09] see [R11]
      endcase
    end else begin
      next_color = dot_bit ? sh_color : bg0[3:0]; // see [R03] see [R06]
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_row <= 8'h00;
      sh_color <= 4'h0;
      dot_idx <= 3'h0;
      loaded <= 1'b0;
      dot_valid <= 1'b0;
      dot_color <= 4'h0;
    end else if (advance) begin
      if (loaded) begin
        dot_color <= next_color; // see [R12]
        dot_valid <= 1'b1;
        dot_idx <= dot_idx + 3'h1;
      end else begin
        dot_valid <= 1'b0;
      end
      if (fifo_pop) begin
        loaded <= fifo_out_valid;
        dot_idx <= 3'h0;
        if (fifo_out_valid) begin
          sh_row <= fifo_out_data[7:0];
          sh_color <= fifo_out_data[11:8];
        end
      end
    end
  end

  // Row advances after each cell; a whole glyph row set is eight rows top down.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_sel <= 3'h0;
    end else if (state == ST_PUSH && fifo_in_ready) begin
      row_sel <= (row_sel == `CCS_ROWS) ? 3'h0 : row_sel + 3'h1; // see [R02]
    end
  end

endmodule // ccs_color_select

////////////////////////////////////////////////////////////////////////////
// Cell FIFO: buffers glyph rows with their colour nibbles between fetch and dots.
// It decouples the memory fetch from a sink that may stall for whole cells.

module ccs_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 4
) (
  input wire pclk,
  input wire presetn,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  localparam AW = (DEPTH <= 2) ? 1 : $clog2(DEPTH);
  localparam [AW-1:0] LAST = DEPTH[AW-1:0] - 1'b1;
  localparam [AW:0] FULL = DEPTH[AW:0];

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  reg [AW-1:0] next_wr_ptr;
  reg [AW-1:0] next_rd_ptr;
  reg [AW:0] next_count;
  wire do_wr;
  wire do_rd;

  assign in_ready = (count != FULL);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  // Pointers wrap at the last entry, so a depth that is not a power of two works too.
  always @* begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (do_wr) begin
      next_wr_ptr = (wr_ptr == LAST) ? {AW{1'b0}} : wr_ptr + 1'b1;
    end
    if (do_rd) begin
      next_rd_ptr = (rd_ptr == LAST) ? {AW{1'b0}} : rd_ptr + 1'b1;
    end
    if (do_wr && !do_rd) begin
      next_count = count + 1'b1;
    end else if (do_rd && !do_wr) begin
      next_count = count - 1'b1;
    end
  end

  // Storage has no reset; out_valid keeps stale words from being seen.
  always @(posedge pclk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

endmodule // ccs_fifo

// *** ccs_color_select_props.sv ***
// Checker for the colour select block, bound to its ports.
// Assumes one clock, pclk, and the asynchronous active-low reset presetn.
`timescale 1ns/1ps
module ccs_color_select_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [31:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire cell_valid,
  input wire cell_ready,
  input wire [7:0] cell_code,
  input wire [13:0] glyph_addr,
  input wire glyph_req,
  input wire glyph_ack,
  input wire [3:0] dot_color,
  input wire dot_valid,
  input wire dot_ready
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_take;
    cell_valid && cell_ready;
  endsequence
  sequence s_high_addr;
    paddr[31:16] != 16'h0000;
  endsequence
  sequence s_wait;
    glyph_req && !glyph_ack;
  endsequence
  sequence s_stall;
    dot_valid && !dot_ready;
  endsequence
  a_apb_answer: assert property (s_access |-> pready) else $error("no answer");
  a_pready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_slverr_pair: assert property (pslverr |-> pready) else $error("lone error");
  a_unmapped_err: assert property ((s_access and s_high_addr) |-> pslverr)
    else $error("unmapped not refused");
  a_glyph_hold: assert property (s_wait |=> glyph_req && $stable(glyph_addr))
    else $error("glyph request dropped");
  a_glyph_index: assert property (
    s_take |=> glyph_req && glyph_addr[10:3] == $past(cell_code))
    else $error("glyph address wrong");
  a_busy_refuse: assert property (glyph_req |-> !cell_ready)
    else $error("busy accept");
  a_dot_hold: assert property (s_stall |=> dot_valid && $stable(dot_color))
    else $error("dot changed");
endmodule // ccs_color_select_props
bind ccs_color_select ccs_color_select_props i_ccs_color_select_props (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .paddr(paddr),
  .pready(pready),
  .pslverr(pslverr),
  .cell_valid(cell_valid),
  .cell_ready(cell_ready),
  .cell_code(cell_code),
  .glyph_addr(glyph_addr),
  .glyph_req(glyph_req),
  .glyph_ack(glyph_ack),
  .dot_color(dot_color),
  .dot_valid(dot_valid),
  .dot_ready(dot_ready)
);

// *** ccs_dot_sink.sv ***
// Video dot sink: takes colour dots and keeps them in arrival order.
// Assumes the colour select block's dot handshake on pclk.
`timescale 1ns/1ps
module ccs_dot_sink (
  input wire pclk,
  input wire presetn,
  input wire [3:0] dot_color,
  input wire dot_valid,
  output logic dot_ready,
  input wire stall,
  input wire slow
);
  logic [3:0] got [$];
  // A stalled display holds ready low so the cell FIFO backs up.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) dot_ready <= 1'b0;
    else begin
      dot_ready <= !stall && !(slow && dot_ready);
      if (dot_valid && dot_ready) got.push_back(dot_color);
    end
  end
endmodule // ccs_dot_sink

// *** testbench.sv ***
// Testbench for the colour select block: APB registers, cells in, dots out.
// Assumes the design files, the dot sink and the checker are compiled first.
`timescale 1ns/1ps
`include "ccs_consts.vh"
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic [31:0] paddr = 0, pwdata = 0, prdata, r;
  logic pready, pslverr, cell_valid = 0, cell_ready, glyph_req, glyph_ack = 0;
  logic dot_valid, dot_ready, stall = 0, slow = 0, mc = 0;
  logic [7:0] cell_code = 0, glyph_row = 0;
  logic [3:0] cell_color = 0, dot_color;
  logic [13:0] glyph_addr;
  logic [3:0] bg [3] = '{4'h1, 4'h3, 4'h6};
  logic [3:0] expq [$];
  int mismatches = 0, checks = 0, rows = 0;
  always #2.5 pclk = ~pclk;
  ccs_color_select i_ccs_color_select (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cell_valid(cell_valid),
    .cell_ready(cell_ready),
    .cell_code(cell_code),
    .cell_color(cell_color),
    .glyph_addr(glyph_addr),
    .glyph_req(glyph_req),
    .glyph_row(glyph_row),
    .glyph_ack(glyph_ack),
    .dot_color(dot_color),
    .dot_valid(dot_valid),
    .dot_ready(dot_ready)
  );
  ccs_dot_sink i_ccs_dot_sink (
    .pclk(pclk),
    .presetn(presetn),
    .dot_color(dot_color),
    .dot_valid(dot_valid),
    .dot_ready(dot_ready),
    .stall(stall),
    .slow(slow)
  );
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
    checks++;
    if (s !== x) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic apb(input logic w, input [31:0] a, input [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Pair 11 carries only three colour bits, so the foreground stays in 0..7.
  function automatic logic [3:0] exp_dot(input logic [3:0] c, input logic [7:0] w, input int k);
    logic [1:0] p = w[7-2*(k/2) -: 2];
    if (!(mc && c[3])) return w[7-k] ? c : bg[0];
    return p == 2'b11 ? {1'b0, c[2:0]} : bg[p];
  endfunction
  task automatic send(input [7:0] c, input [3:0] col, input [7:0] w);
    int n = 0;
    @(posedge pclk);
    cell_valid <= 1;
    cell_code <= c;
    cell_color <= col;
    do @(posedge pclk); while (cell_ready !== 1'b1 && n++ < 900);
    cell_valid <= 0;
    do @(posedge pclk); while (glyph_req !== 1'b1 && n++ < 900);
    chk("glyph addr", 32'h3000 + c * 8 + rows % 8, glyph_addr);
    rows++;
    glyph_ack <= 1;
    glyph_row <= w;
    @(posedge pclk);
    glyph_ack <= 0;
    glyph_row <= ~w;
    for (int k = 0; k < 8; k++) expq.push_back(exp_dot(col, w, k));
  endtask
  task automatic drain;
    int n = 0;
    stall <= 0;
    while (i_ccs_dot_sink.got.size() < expq.size() && n++ < 900) @(posedge pclk);
    chk("dot count", expq.size(), i_ccs_dot_sink.got.size());
    foreach (expq[k]) chk("dot", expq[k], i_ccs_dot_sink.got[k]);
    expq.delete();
    i_ccs_dot_sink.got.delete();
  endtask
  task automatic mode(input logic m);
    mc = m;
    apb(1, `CCS_OFF_CTRL2, m ? 32'h10 : 32'h0);
    apb(0, `CCS_OFF_CTRL2, 0);
    chk("ctrl", m ? 32'h10 : 32'h0, r);
  endtask
  task automatic t_regs;
    apb(0, `CCS_OFF_BG1, 0);
    chk("bg1 reset", `CCS_RST_REG, r);
    apb(0, `CCS_OFF_MEMSET, 0);
    chk("memset reset", `CCS_RST_MEMSET, r);
    for (int i = 0; i < 3; i++) begin
      apb(1, `CCS_OFF_BG0 + i, bg[i]);
      apb(0, `CCS_OFF_BG0 + i, 0);
      chk("bg reg", bg[i], r);
    end
    apb(1, 32'h0001D021, 5);
    chk("unmapped err", 1, e);
    apb(0, `CCS_OFF_BG0, 0);
    chk("bg0 kept", bg[0], r);
  endtask
  task automatic t_std;
    mode(0);
    send(8'h14, 4'hD, 8'hA5);
    send(8'hFF, 4'h7, 8'h01);
    drain;
  endtask
  task automatic t_mc;
    mode(1);
    stall <= 1;
    send(8'h00, 4'h5, 8'h3C);
    send(8'h01, 4'hD, 8'h1B);
    send(8'h02, 4'h8, 8'hE4);
    send(8'h03, 4'hF, 8'hFF);
    drain;
  endtask
  task automatic t_live;
    bg[1] = 4'h9;
    apb(1, `CCS_OFF_BG1, 32'h9);
    slow <= 1;
    send(8'h05, 4'hA, 8'h55);
    drain;
  endtask
  task automatic stop_test;
    if (mismatches == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    t_regs;
    t_std;
    t_mc;
    t_live;
    stop_test;
  end
  initial begin
    #200000;
    mismatches++;
    stop_test;
  end
endmodule // testbench
